//--- design/godr_pad.sv
/*
 per-pad driver decode: push-pull or open-drain, input or output.
 assumes registered inputs from the register file on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module godr_pad (
	input wire logic od_en,
	input wire logic dir_out,
	input wire logic data_out,
	output logic pad_out,
	output logic pad_oe
);
	// open drain only ever pulls low, so out is fixed at zero
	always_comb begin
		if (!dir_out) begin
			pad_out = 1'b0; // RL4
			pad_oe = 1'b0; // RL4
		end else if (od_en) begin
			pad_out = 1'b0; // RL5
			pad_oe = ~data_out; // RL5
		end else begin
			pad_out = data_out; // RL2
			pad_oe = 1'b1;
		end
	end
endmodule // godr_pad
`default_nettype wire

//--- design/godr_pkg.sv
/*
 constants for the open-drain select block: register offsets, field layout, resets.
 assumes a 32-bit classic wishbone bus with byte addresses.
*/
`default_nettype none
package godr_pkg;
	localparam int GODR_PADS = 8;
	localparam int GODR_ADDR_W = 12;
	localparam logic [11:0] GODR_OPEN_DRAIN_SELECT_OFS = 12'h50C;
	localparam logic [11:0] GODR_DIRECTION_OFS = 12'h400;
	localparam logic [11:0] GODR_DIGITAL_EN_OFS = 12'h51C;
	localparam logic [11:0] GODR_PAD_STATE_OFS = 12'h3FC;
	localparam logic [11:0] GODR_DATA_OUT_OFS = 12'h3F8;
	localparam logic [7:0] GODR_FIELD_RESET = 8'h00;
	localparam logic [23:0] GODR_RESERVED_READ = 24'h000000;
	localparam logic [31:0] GODR_UNMAPPED_READ = 32'h00000000;
endpackage : godr_pkg
`default_nettype wire

//--- design/godr_sync.sv
/*
 two-flop synchroniser for the pad inputs.
 assumes pad levels are asynchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module godr_sync
	import godr_pkg::*;
#(
	parameter int WIDTH = GODR_PADS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} godr_sync_type;
	godr_sync_type st_reg, st_next;

	// first stage is read only by the second
	always_comb begin
		st_next.meta = async_in;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.stable;
endmodule // godr_sync
`default_nettype wire

//--- design/godr_top.sv
/*
 open-drain select port block with its wishbone register file and pad drivers.
 assumes a classic wishbone master on mclk and pads with tristate buffers outside.
*/
// What this block does
// RL1 - bit n sets open drain for pad n
// RL2 - zero disables, one enables open drain
// RL3 - field reads all zeros after reset
// RL4 - open drain with direction zero: input
// RL5 - open drain with direction one: output
// RL6 - software should also set digital enable
// RL7 - upper bits reserved, read only, preserved
// RL8 - whole field written at once, applies next
`timescale 1ns/1ns
`default_nettype none
module godr_top
	import godr_pkg::*;
#(
	parameter int PADS = GODR_PADS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [GODR_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PADS-1:0] pad_in,
	output logic [PADS-1:0] pad_out,
	output logic [PADS-1:0] pad_oe,
	output logic [PADS-1:0] pad_digital_en
);
	typedef struct packed {
		logic [PADS-1:0] pad_open_drain_en;
		logic [PADS-1:0] pin_direction_reg;
		logic [PADS-1:0] digital_input_enable_reg;
		logic [PADS-1:0] data_out;
		logic [PADS-1:0] pad_out;
		logic [PADS-1:0] pad_oe;
		logic [PADS-1:0] pad_digital_en;
		logic [31:0] dat;
		logic ack;
	} godr_state_type;

	godr_state_type st_reg, st_next;
	logic [PADS-1:0] pad_sync;
	logic [PADS-1:0] drv_out;
	logic [PADS-1:0] drv_oe;
	logic req;

	// merge a byte-lane write into the low field only
	function automatic logic [PADS-1:0] lane_write(input logic [PADS-1:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		lane_write = sel[0] ? d[PADS-1:0] : old;
	endfunction

	// widen a field to a bus word, reserved bits as zero
	function automatic logic [31:0] word_of(input logic [PADS-1:0] f);
		word_of = {GODR_RESERVED_READ, f};
	endfunction

	////////////////////////////////////////////////////////////////
	godr_sync #(.WIDTH(PADS)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(pad_in),
		.sync_out(pad_sync)
	);

	genvar g;
	generate
		for (g = 0; g < PADS; g++) begin : g_pad
			godr_pad u_pad (
				.od_en(st_reg.pad_open_drain_en[g]), // RL1
				.dir_out(st_reg.pin_direction_reg[g]),
				.data_out(st_reg.data_out[g]),
				.pad_out(drv_out[g]),
				.pad_oe(drv_oe[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// one-wait-state slave: ack the cycle after the request, drop after
	assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;

	always_comb begin
		st_next = st_reg;
		st_next.ack = req;
		st_next.pad_out = drv_out;
		st_next.pad_oe = drv_oe;
		st_next.pad_digital_en = st_reg.digital_input_enable_reg;
		if (req) begin
			case (wb_adr_i)
				GODR_OPEN_DRAIN_SELECT_OFS: begin
					st_next.dat = word_of(st_reg.pad_open_drain_en); // RL7
					if (wb_we_i) begin
						// upper bits ignored, whole field in one access
						st_next.pad_open_drain_en =
							lane_write(st_reg.pad_open_drain_en, wb_dat_i, wb_sel_i); // RL8
					end
				end
				GODR_DIRECTION_OFS: begin
					st_next.dat = word_of(st_reg.pin_direction_reg);
					if (wb_we_i) begin
						st_next.pin_direction_reg =
							lane_write(st_reg.pin_direction_reg, wb_dat_i, wb_sel_i);
					end
				end
				GODR_DIGITAL_EN_OFS: begin
					// not forced by open drain; software's job
					st_next.dat = word_of(st_reg.digital_input_enable_reg); // RL6
					if (wb_we_i) begin
						st_next.digital_input_enable_reg =
							lane_write(st_reg.digital_input_enable_reg, wb_dat_i, wb_sel_i);
					end
				end
				GODR_DATA_OUT_OFS: begin
					st_next.dat = word_of(st_reg.data_out);
					if (wb_we_i) begin
						st_next.data_out = lane_write(st_reg.data_out, wb_dat_i, wb_sel_i);
					end
				end
				GODR_PAD_STATE_OFS: begin
					// gated by digital enable so floating pads read zero
					st_next.dat = word_of(pad_sync & st_reg.digital_input_enable_reg);
				end
				default: begin
					st_next.dat = GODR_UNMAPPED_READ;
				end
			endcase
		end
	end

	// everything resets to zero, open drain off on all pads
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.pad_open_drain_en <= GODR_FIELD_RESET; // RL3
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.dat;
	assign wb_ack_o = st_reg.ack;
	assign pad_out = st_reg.pad_out;
	assign pad_oe = st_reg.pad_oe;
	assign pad_digital_en = st_reg.pad_digital_en;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic wr_od;
	assign wr_od = req && wb_we_i && wb_sel_i[0] && wb_adr_i == GODR_OPEN_DRAIN_SELECT_OFS;

	reset_zero_a: assert property ($rose(rst_n) |-> st_reg.pad_open_drain_en == GODR_FIELD_RESET) // RL3
		else $error("open drain field not zero after reset");
	write_takes_a: assert property (wr_od |=> st_reg.pad_open_drain_en == $past(wb_dat_i[PADS-1:0])) // RL8
		else $error("open drain write not applied");
	hold_field_a: assert property (!wr_od |=> $stable(st_reg.pad_open_drain_en)) // RL1
		else $error("open drain field changed without write");
	reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:PADS] == '0) // RL7
		else $error("reserved bits nonzero");
	od_input_a: assert property ((st_reg.pad_open_drain_en[0] && !st_reg.pin_direction_reg[0])
		|=> !pad_oe[0]) // RL4
		else $error("open drain input pad driving");
	od_output_a: assert property ((st_reg.pad_open_drain_en[0] && st_reg.pin_direction_reg[0])
		|=> pad_oe[0] == !$past(st_reg.data_out[0]) && !pad_out[0]) // RL5
		else $error("open drain output wrong drive");
	push_pull_a: assert property ((!st_reg.pad_open_drain_en[0] && st_reg.pin_direction_reg[0])
		|=> pad_oe[0] && pad_out[0] == $past(st_reg.data_out[0])) // RL2
		else $error("push pull pad wrong drive");
	ack_one_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");

	od_write_c: cover property (wr_od);
	od_drive_low_c: cover property (pad_oe[0] && !pad_out[0] && st_reg.pad_open_drain_en[0]);
	unmapped_c: cover property (req && wb_adr_i == UNMAPPED_PROBE);
	od_input_c: cover property (st_reg.pad_open_drain_en[0] && !st_reg.pin_direction_reg[0]);
	push_pull_c: cover property (pad_oe[0] && pad_out[0] && !st_reg.pad_open_drain_en[0]);

	////////////////////////////////////////////////////////////////
	// probe address for the unmapped-read checks; any word outside the map
	// would do, this one sits well below every decoded offset
	localparam logic [11:0] UNMAPPED_PROBE = 12'h000;

	////////////////////////////////////////////////////////////////
	// bus-side checks beyond the single-cycle ack
	// ack is never given twice in a row, so a master that keeps
	// cyc and stb high sees a gap before the next request is taken
	ack_no_repeat_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack given two cycles in a row");

	// no request, no answer: a stray ack would complete a cycle early
	ack_idle_low_a: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");

	// read data of the field is the field as it stood when taken
	od_read_a: assert property ((req && !wb_we_i && wb_adr_i == GODR_OPEN_DRAIN_SELECT_OFS)
		|=> wb_dat_o[PADS-1:0] == $past(st_reg.pad_open_drain_en)) // RL1
		else $error("open drain read data wrong");

	// unmapped words answer with the fixed unmapped value
	unmapped_read_a: assert property ((req && wb_adr_i == UNMAPPED_PROBE)
		|=> wb_dat_o == GODR_UNMAPPED_READ) // RL7
		else $error("unmapped read not fixed value");

	// unmapped writes must not leak into the field
	unmapped_write_a: assert property ((req && wb_we_i && wb_adr_i == UNMAPPED_PROBE)
		|=> $stable(st_reg.pad_open_drain_en)) // RL7
		else $error("unmapped write changed field");

	////////////////////////////////////////////////////////////////
	// digital enable is only mirrored, never forced by open drain;
	// software is expected to set it alongside the field
	digital_copy_a: assert property (1'b1
		|=> pad_digital_en == $past(st_reg.digital_input_enable_reg))
		else $error("digital enable output not a copy");

	////////////////////////////////////////////////////////////////
	// per-pad drive checks; the pad-0 checks above catch the common
	// case, these make sure no pad is wired to a neighbour's bits
	genvar p;
	generate
		for (p = 0; p < PADS; p++) begin : g_chk
			// direction zero never drives, whatever the field says
			dir_in_idle_a: assert property (!st_reg.pin_direction_reg[p]
				|=> !pad_oe[p] && !pad_out[p]) // RL4
				else $error("input pad driving");

			// open drain output pulls low on a zero, lets go on a one
			od_low_only_a: assert property ((st_reg.pad_open_drain_en[p]
				&& st_reg.pin_direction_reg[p])
				|=> !pad_out[p] && pad_oe[p] == !$past(st_reg.data_out[p])) // RL5
				else $error("open drain pad drove high");

			// field bit clear keeps the pad in push-pull
			push_pull_pad_a: assert property ((!st_reg.pad_open_drain_en[p]
				&& st_reg.pin_direction_reg[p])
				|=> pad_oe[p] && pad_out[p] == $past(st_reg.data_out[p])) // RL2
				else $error("push pull pad wrong");

			// an open drain pad can never be seen driving high
			never_high_a: assert property ((st_reg.pad_open_drain_en[p])
				|=> !(pad_oe[p] && pad_out[p])) // RL1
				else $error("open drain pad high");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// limitations worth knowing
	// the field change shows on the pads one cycle after the write
	// lands, because the pad drive is registered to keep the outputs
	// glitch free; software that toggles open drain and data in two
	// writes sees an intermediate state for at least two cycles in between.
	// reserved bits always read zero here rather than an unknown
	// value, so a read-modify-write by software preserves them for free.
	// writes with byte lane zero disabled leave every field untouched,
	// since all fields of this block live in that lane.
endmodule // godr_top
`default_nettype wire

//--- verification/godr_top_tb.sv
/*
 self-checking bench for the open-drain select block: register access and pad drive.
 assumes godr_top on a classic wishbone bus, mclk at 25 MHz, synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module godr_top_tb import godr_pkg::*;;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [GODR_ADDR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] pad_in = 8'h00;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;
	logic [7:0] pad_digital_en;
	logic [31:0] rd;
	logic [7:0] od;
	int n_fail = 0;
	int comparisons = 0;

	////////////////////////////////////////////////////////////////////////////////
	// clock and design
	always #20 mclk = ~mclk;

	godr_top i_godr_top (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_digital_en(pad_digital_en));

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one classic cycle; request held until ack is sampled, never a fixed latency
	task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: whole run is well under 1000 cycles
	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		wb(1'b0, GODR_OPEN_DRAIN_SELECT_OFS, 32'h0, rd);
		check("odr reset", rd, 32'h0);
		check("oe reset", 32'(pad_oe), 32'h0);
		// software sets digital enable along with open drain
		wb(1'b1, GODR_DIGITAL_EN_OFS, 32'hFF, rd);
		wb(1'b1, GODR_DIRECTION_OFS, 32'h0F, rd);
		wb(1'b1, GODR_DATA_OUT_OFS, 32'h55, rd);
		// walk one bit per pad, then all and none; upper data bits junk to test ignore
		for (int i = 0; i < 10; i++) begin
			od = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hFF : 8'h00);
			wb(1'b1, GODR_OPEN_DRAIN_SELECT_OFS, {24'hA5C3F0, od}, rd);
			repeat (2) @(posedge mclk);
			check("pad oe", 32'(pad_oe), 32'(8'h0F & ~(od & 8'h55)));
			check("pad drive", 32'(pad_out & pad_oe), 32'(8'h0F & ~od & 8'h55));
			wb(1'b0, GODR_OPEN_DRAIN_SELECT_OFS, 32'h0, rd);
			check("odr read", rd, {24'h0, od});
		end
		check("digital en", 32'(pad_digital_en), 32'hFF);
		// input pads still read their level, with open drain now off on every pad
		pad_in <= 8'hA5;
		repeat (4) @(posedge mclk);
		wb(1'b0, GODR_PAD_STATE_OFS, 32'h0, rd);
		check("pad state", rd, 32'hA5);
		wb(1'b0, 12'h000, 32'h0, rd);
		check("unmapped", rd, GODR_UNMAPPED_READ);
		print_verdict();
	end
endmodule // godr_top_tb
`default_nettype wire
